// >>> gpc_pkg.sv
// constants shared by the gated pulse counter: register offsets, field
// positions, reset values and code points.
// assumes a 32-bit avalon-mm slave with byte addresses.
package gpc_pkg;
  // --------------------------------------------------
  // channel geometry
  // --------------------------------------------------
  localparam int NCH = 8;
  localparam int CHW = 3;
  // --------------------------------------------------
  // register byte offsets
  // --------------------------------------------------
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_CHEN = 6'h04;
  localparam logic [5:0] OFS_DQ = 6'h08;
  localparam logic [5:0] OFS_DGEN = 6'h0C;
  localparam logic [5:0] OFS_LIMIT = 6'h10;
  localparam logic [5:0] OFS_CMP = 6'h14;
  localparam logic [5:0] OFS_COUNT = 6'h18;
  localparam logic [5:0] OFS_WIN = 6'h1C;
  localparam logic [5:0] OFS_FREQ = 6'h20;
  localparam logic [5:0] OFS_DGST = 6'h24;
  localparam logic [5:0] OFS_IREC = 6'h28;
  // --------------------------------------------------
  // control field positions
  // --------------------------------------------------
  localparam int F_MODE = 0;
  localparam int F_EDGE = 1;
  localparam int F_SWG = 3;
  localparam int F_HWEN = 4;
  localparam int F_STOP = 5;
  localparam int F_IRQEN = 6;
  localparam int F_CNTCH = 8;
  localparam int F_GATECH = 12;
  localparam int F_DQCH = 16;
  // --------------------------------------------------
  // codes and reset values
  // --------------------------------------------------
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [7:0] EV_CMP = 8'h05;
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] RST_LIMIT = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_CMP = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_WIN = 32'h0098_9680;
endpackage : gpc_pkg

// >>> gated_pulse_counter_with_diag.sv
// gated pulse counter with frequency mode and output diagnostics.
// assumes field pins and sense inputs are asynchronous; bus is avalon-mm.
//
// Operation
// - count on rising, falling or both edges as configured
// - with hardware gate on, internal gate is gate pin AND software gate
// - pulses count only while the internal gate is open
// - in counter mode the gate decides when pulses enter the count
// - in frequency mode the gate defines the measuring window
// - any channel may be chosen as the hardware gate input
// - in counter mode, compare result drives a chosen channel as digital output
// - a single control bit locks or enables the compare interrupt
// - short to ground flagged only while the output drives one
// - driving the output to zero clears a short to ground flag
// - enabled short-to-supply detection raises its flag
// - enabled wire-break detection on an active channel raises its flag
// - short diagnostics act only on output channels, per channel or all
// - each channel has an enable; disabled ones neither count nor diagnose
// - past high limit wrap to zero; continue or halt until gate reopens
// - frequency counts rising edges per window, no edge timing
// - interrupt carries channel number and compare event code
// - interrupt only in counter mode
`timescale 1ns/100ps
module gated_pulse_counter_with_diag
  import gpc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [5:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [NCH-1:0] io_in_i,
  input wire logic [NCH-1:0] sense_gnd_i,
  input wire logic [NCH-1:0] sense_sup_i,
  input wire logic [NCH-1:0] sense_open_i,
  output logic [NCH-1:0] io_out_o,
  output logic [NCH-1:0] io_oe_o,
  output logic hw_irq_o,
  output logic [7:0] irq_chan_o,
  output logic [7:0] irq_event_o
);
  // --------------------------------------------------
  // declarations
  // --------------------------------------------------
  logic [4*NCH-1:0] s1_q, s2_q;
  logic [NCH-1:0] prev_q;
  logic [31:0] ctrl_q, dq_q, dgen_q, lim_q, cmp_q, win_len_q;
  logic [NCH-1:0] en_q, gnd_q, sup_q, wb_q, gnd_d, sup_d, wb_d;
  logic [NCH-1:0] out_q;
  logic [31:0] count_q, count_d, win_q, acc_q, freq_q;
  logic halt_q, halt_d, gate_prev_q, cmp_prev_q, wait_q;
  logic [31:0] rd_w, wmask_w;
  logic [NCH-1:0] pin_w, rise_w, fall_w, hit_w, dir_w;
  logic mode_w, swg_w, hwen_w, stop_w, irqen_w;
  logic [1:0] esel_w;
  logic [CHW-1:0] cnt_ch_w, gate_ch_w, dq_ch_w;
  logic src_rise_w, src_fall_w, edge_w, hw_lvl_w, gate_w, gate_rise_w;
  logic pulse_w, wrap_w, cmp_w, irq_w, fpos_w, win_end_w;
  logic req_w, take_w, wr_w;
  logic [NCH-1:0] chen_wd_w;

  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  // two stages before any logic; edges come from stage two only
  always_ff @(posedge clock_i) begin
    s1_q <= {sense_open_i, sense_sup_i, sense_gnd_i, io_in_i};
    s2_q <= s1_q;
    prev_q <= s2_q[NCH-1:0];
  end
  assign pin_w = s2_q[NCH-1:0];
  assign rise_w = pin_w & ~prev_q;
  assign fall_w = ~pin_w & prev_q;

  // --------------------------------------------------
  // control field decode
  // --------------------------------------------------
  assign mode_w = ctrl_q[F_MODE];
  assign esel_w = ctrl_q[F_EDGE+:2];
  assign swg_w = ctrl_q[F_SWG];
  assign hwen_w = ctrl_q[F_HWEN];
  assign stop_w = ctrl_q[F_STOP];
  assign irqen_w = ctrl_q[F_IRQEN];
  assign cnt_ch_w = ctrl_q[F_CNTCH+:CHW];
  assign gate_ch_w = ctrl_q[F_GATECH+:CHW];
  assign dq_ch_w = ctrl_q[F_DQCH+:CHW];
  assign dir_w = dq_q[2*NCH-1:NCH];

  // --------------------------------------------------
  // edge selection and internal gate
  // --------------------------------------------------
  // code 3 behaves as both edges so no setting leaves the counter dead
  assign src_rise_w = rise_w[cnt_ch_w];
  assign src_fall_w = fall_w[cnt_ch_w];
  assign edge_w = (esel_w == EDGE_RISE) ? src_rise_w :
                  (esel_w == EDGE_FALL) ? src_fall_w :
                  (src_rise_w | src_fall_w);
  assign hw_lvl_w = pin_w[gate_ch_w] & en_q[gate_ch_w];
  assign gate_w = swg_w & (~hwen_w | hw_lvl_w) & en_q[cnt_ch_w];
  assign gate_rise_w = gate_w & ~gate_prev_q;

  // --------------------------------------------------
  // counter operation
  // --------------------------------------------------
  assign pulse_w = ~mode_w & gate_w & edge_w & ~halt_q;
  assign wrap_w = (count_q == lim_q);
  assign count_d = !pulse_w ? count_q :
                   wrap_w ? 32'h0 : count_q + 32'h1;
  // halt is released only by a fresh gate opening after closure
  assign halt_d = (halt_q & ~gate_rise_w) | (pulse_w & wrap_w & stop_w);
  assign cmp_w = (count_q >= cmp_q);
  assign irq_w = cmp_w & ~cmp_prev_q & ~mode_w & irqen_w;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_q <= 32'h0;
      halt_q <= 1'b0;
      gate_prev_q <= 1'b0;
      cmp_prev_q <= 1'b0;
    end else begin
      count_q <= count_d;
      halt_q <= halt_d;
      gate_prev_q <= gate_w;
      cmp_prev_q <= cmp_w;
    end
  end

  // --------------------------------------------------
  // frequency measurement
  // --------------------------------------------------
  // only rising edges inside the window; software divides by window time
  assign fpos_w = mode_w & gate_w & src_rise_w;
  assign win_end_w = (win_q == win_len_q - 32'h1);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      win_q <= 32'h0;
      acc_q <= 32'h0;
      freq_q <= 32'h0;
    end else if (!(mode_w & gate_w)) begin
      win_q <= 32'h0;
      acc_q <= 32'h0;
    end else if (win_end_w) begin
      win_q <= 32'h0;
      acc_q <= 32'h0;
      freq_q <= acc_q + {31'h0, fpos_w};
    end else begin
      win_q <= win_q + 32'h1;
      acc_q <= acc_q + {31'h0, fpos_w};
    end
  end

  // --------------------------------------------------
  // output drive and interrupt record
  // --------------------------------------------------
  // compare channel overrides the software value while counting
  assign hit_w = mode_w ? 8'h00 : (8'h01 << dq_ch_w);

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      out_q <= 8'h00;
      io_oe_o <= 8'h00;
      hw_irq_o <= 1'b0;
      irq_chan_o <= 8'h00;
      irq_event_o <= 8'h00;
    end else begin
      out_q <= ((dq_q[NCH-1:0] & ~hit_w) | (hit_w & {NCH{cmp_w}})) & en_q & dir_w;
      io_oe_o <= en_q & dir_w;
      hw_irq_o <= irq_w;
      if (irq_w) begin
        irq_chan_o <= {5'h0, cnt_ch_w};
        irq_event_o <= EV_CMP;
      end
    end
  end
  assign io_out_o = out_q;

  // --------------------------------------------------
  // diagnostics latches
  // --------------------------------------------------
  // a short to ground cannot be seen with the driver off, so clear then
  assign gnd_d = (gnd_q | s2_q[2*NCH-1:NCH]) & out_q
               & en_q & dir_w & dgen_q[NCH-1:0];
  assign sup_d = (sup_q | s2_q[3*NCH-1:2*NCH])
               & en_q & dir_w & dgen_q[2*NCH-1:NCH];
  assign wb_d = (wb_q | s2_q[4*NCH-1:3*NCH])
              & en_q & dgen_q[3*NCH-1:2*NCH];

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      gnd_q <= 8'h00;
      sup_q <= 8'h00;
      wb_q <= 8'h00;
    end else begin
      gnd_q <= gnd_d;
      sup_q <= sup_d;
      wb_q <= wb_d;
    end
  end

  // --------------------------------------------------
  // avalon-mm slave
  // --------------------------------------------------
  // one wait state on every access; unmapped reads return zero
  assign req_w = read_i | write_i;
  assign take_w = req_w & ~wait_q;
  assign wr_w = write_i & take_w;
  assign chen_wd_w = (en_q & ~wmask_w[NCH-1:0]) | (writedata_i[NCH-1:0] & wmask_w[NCH-1:0]);
  assign wmask_w = {{8{byteenable_i[3]}}, {8{byteenable_i[2]}},
                    {8{byteenable_i[1]}}, {8{byteenable_i[0]}}};
  assign rd_w = (address_i == OFS_CTRL) ? ctrl_q :
                (address_i == OFS_CHEN) ? {24'h0, en_q} :
                (address_i == OFS_DQ) ? dq_q :
                (address_i == OFS_DGEN) ? dgen_q :
                (address_i == OFS_LIMIT) ? lim_q :
                (address_i == OFS_CMP) ? cmp_q :
                (address_i == OFS_COUNT) ? count_q :
                (address_i == OFS_WIN) ? win_len_q :
                (address_i == OFS_FREQ) ? freq_q :
                (address_i == OFS_DGST) ? {8'h0, wb_q, sup_q, gnd_q} :
                (address_i == OFS_IREC) ? {16'h0, irq_event_o, irq_chan_o} :
                32'h0;

  function automatic logic [31:0] mrg(input logic [31:0] old);
    mrg = (old & ~wmask_w) | (writedata_i & wmask_w);
  endfunction : mrg

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      wait_q <= 1'b1;
      readdata_o <= 32'h0;
    end else begin
      wait_q <= ~(req_w & wait_q);
      if (read_i & wait_q) readdata_o <= rd_w;
    end
  end
  assign waitrequest_o = wait_q;

  // configuration registers, written at the accepting edge only
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_q <= RST_CTRL;
      en_q <= 8'h00;
      dq_q <= 32'h0;
      dgen_q <= 32'h0;
      lim_q <= RST_LIMIT;
      cmp_q <= RST_CMP;
      win_len_q <= RST_WIN;
    end else if (wr_w) begin
      if (address_i == OFS_CTRL) ctrl_q <= mrg(ctrl_q);
      if (address_i == OFS_CHEN) en_q <= chen_wd_w; // byte lane zero only
      if (address_i == OFS_DQ) dq_q <= mrg(dq_q) & 32'h0000_FFFF;
      if (address_i == OFS_DGEN) dgen_q <= mrg(dgen_q) & 32'h00FF_FFFF;
      if (address_i == OFS_LIMIT) lim_q <= mrg(lim_q);
      if (address_i == OFS_CMP) cmp_q <= mrg(cmp_q);
      if (address_i == OFS_WIN) win_len_q <= mrg(win_len_q);
    end
  end

  // --------------------------------------------------
  // assertions
  // --------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  sequence s_wrap_stop;
    pulse_w && wrap_w && stop_w;
  endsequence
  sequence s_halted;
    halt_q && !gate_rise_w;
  endsequence
  sequence s_wrap_run;
    pulse_w && wrap_w && !stop_w;
  endsequence
  sequence s_reopen;
    halt_q && gate_rise_w;
  endsequence

  a_count_step: assert property (pulse_w && !wrap_w |=> count_q == $past(count_q) + 32'h1)
    else $error("count did not step on a qualifying edge");
  a_gate_holds: assert property (!gate_w && !mode_w |=> count_q == $past(count_q))
    else $error("count moved with gate closed");
  a_hw_gate_and: assert property (hwen_w && !hw_lvl_w |-> !pulse_w)
    else $error("pulse counted with hardware gate low");
  a_wrap_halt: assert property (s_wrap_stop |=> count_q == 32'h0 && halt_q)
    else $error("stop mode wrap did not halt at zero");
  a_irq_mode: assert property (hw_irq_o |-> $past(!mode_w && irqen_w))
    else $error("interrupt outside counter mode or while locked");
  a_irq_code: assert property (irq_w |=> hw_irq_o && irq_event_o == EV_CMP)
    else $error("interrupt record wrong");
  a_gnd_on_only: assert property (1 |=> (gnd_q & ~$past(gnd_q) & ~$past(out_q)) == 8'h00)
    else $error("ground short flagged with output off");
  a_gnd_clear: assert property (1 |=> (gnd_q & ~$past(out_q)) == 8'h00)
    else $error("ground short not cleared by output zero");
  a_disabled_quiet: assert property (1 |=> ((gnd_q | sup_q | wb_q) & ~$past(en_q)) == 8'h00)
    else $error("diagnostic on disabled channel");
  a_dq_drive: assert property (!mode_w && en_q[dq_ch_w] && dir_w[dq_ch_w] && $stable(dq_ch_w)
                               |=> out_q[$past(dq_ch_w)] == $past(cmp_w))
    else $error("compare output not driven");
  a_bus_answer: assert property (req_w && wait_q |=> !waitrequest_o)
    else $error("bus access not answered in one cycle");

  // --------------------------------------------------
  // assertions: limit, edges and frequency window
  // --------------------------------------------------
  // halt must survive until a fresh gate opening, then let go at once
  a_wrap_run: assert property (s_wrap_run |=> count_q == 32'h0 && !halt_q)
    else $error("continue mode wrap did not run on from zero");
  a_halt_holds: assert property (s_halted |=> halt_q && count_q == $past(count_q))
    else $error("halted counter moved or released early");
  a_halt_release: assert property (s_reopen |=> !halt_q)
    else $error("gate reopening did not release halt");
  a_fall_only: assert property (esel_w == EDGE_FALL && !src_fall_w |=> count_q == $past(count_q))
    else $error("count moved without a falling edge");
  a_count_freeze: assert property (mode_w |=> count_q == $past(count_q))
    else $error("count moved in frequency mode");
  a_window_reset: assert property (!(mode_w && gate_w) |=> win_q == 32'h0 && acc_q == 32'h0)
    else $error("window not discarded with gate closed");
  a_window_count: assert property (mode_w && gate_w && !win_end_w |=> win_q == $past(win_q) + 32'h1)
    else $error("window did not advance while open");
  a_freq_latch: assert property (mode_w && gate_w && win_end_w
                                 |=> freq_q == $past(acc_q) + {31'h0, $past(fpos_w)})
    else $error("frequency result not latched at window end");

  // --------------------------------------------------
  // assertions: interrupt record, drivers and flags
  // --------------------------------------------------
  // flags are sticky, so a lost flag is as bad as a false one
  a_irq_lock: assert property (!irqen_w |=> !hw_irq_o)
    else $error("interrupt raised while locked");
  a_irq_chan: assert property (irq_w |=> irq_chan_o == {5'h0, $past(cnt_ch_w)})
    else $error("interrupt record carries wrong channel");
  a_oe_follow: assert property (1 |=> io_oe_o == $past(en_q & dir_w))
    else $error("driver enable does not follow channel setup");
  a_sup_output_only: assert property (1 |=> (sup_q & ~$past(dir_w)) == 8'h00)
    else $error("supply short flagged on an input channel");
  a_sup_hold: assert property (1 |=> (($past(sup_q) & $past(en_q) & $past(dir_w)
                               & $past(dgen_q[2*NCH-1:NCH])) & ~sup_q) == 8'h00)
    else $error("supply short flag dropped while enabled");
  a_wb_hold: assert property (1 |=> (($past(wb_q) & $past(en_q)
                              & $past(dgen_q[3*NCH-1:2*NCH])) & ~wb_q) == 8'h00)
    else $error("wire break flag dropped while enabled");
endmodule : gated_pulse_counter_with_diag

// >>> field_model.sv
// field side model: pulse source on channel 0, gate pin, actuators, fault sense.
// assumes the bench calls its tasks from one process at a time.
`timescale 1ns/100ps
module field_model
  import gpc_pkg::*;
(
  input wire logic clock_i,
  input wire logic [NCH-1:0] io_out_i,
  input wire logic [NCH-1:0] io_oe_i,
  output logic [NCH-1:0] io_in_o,
  output logic [NCH-1:0] sense_gnd_o,
  output logic [NCH-1:0] sense_sup_o,
  output logic [NCH-1:0] sense_open_o
);
  logic [NCH-1:0] drive_q = '0;
  logic run_q = 1'b0;
  logic [3:0] tick_q = '0;
  // no fault sensed until a scenario injects one
  initial begin
    sense_gnd_o = '0;
    sense_sup_o = '0;
    sense_open_o = '0;
  end
  // a driven pin reads back its own level, otherwise the field source wins
  assign io_in_o = (io_oe_i & io_out_i) | (~io_oe_i & drive_q);
  // free-running source, 10 cycles a period, so a window holds whole periods
  always @(posedge clock_i) begin
    if (run_q) begin
      tick_q <= (tick_q == 4'h9) ? 4'h0 : tick_q + 4'h1;
      if (tick_q == 4'h0 || tick_q == 4'h5) begin
        drive_q[0] <= ~drive_q[0];
      end
    end
  end
  // slow pulses, 3 cycles high and 4 low, well above the synchroniser depth
  task pulses(input int n);
    repeat (n) begin
      @(posedge clock_i);
      drive_q[0] <= 1'b1;
      repeat (3) @(posedge clock_i);
      drive_q[0] <= 1'b0;
      repeat (3) @(posedge clock_i);
    end
  endtask : pulses
  task set_pin(input int ch, input logic lvl);
    @(posedge clock_i);
    drive_q[ch] <= lvl;
    repeat (5) @(posedge clock_i);
  endtask : set_pin
  task set_sense(input logic [NCH-1:0] g, input logic [NCH-1:0] s, input logic [NCH-1:0] o);
    @(posedge clock_i);
    sense_gnd_o <= g;
    sense_sup_o <= s;
    sense_open_o <= o;
    repeat (5) @(posedge clock_i);
  endtask : set_sense
  // stopping waits two edges so the toggle process never collides with the park
  task run(input logic on);
    @(posedge clock_i);
    run_q <= on;
    repeat (2) @(posedge clock_i);
    if (!on) begin
      drive_q[0] <= 1'b0;
    end
  endtask : run
endmodule : field_model

// >>> tb_top.sv
// self-checking bench: counting table, then reset, compare, limit, frequency, diag.
// assumes the package, the design and field_model are compiled before it.
`timescale 1ns/100ps
module tb_top;
  import gpc_pkg::*;
  typedef struct {logic [31:0] ctrl; logic [7:0] chen; logic gate; logic [31:0] cnt;} row_t;
  logic clock_i = 0, reset_i = 1, read_i = 0, write_i = 0, waitrequest_o, hw_irq_o;
  logic [5:0] address_i = '0;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] writedata_i = '0, readdata_o, rd;
  logic [NCH-1:0] io_in_i, sense_gnd_i, sense_sup_i, sense_open_i, io_out_o, io_oe_o;
  logic [7:0] irq_chan_o, irq_event_o;
  int errors = 0, n_checks = 0, cyc = 0, irqs = 0;
  row_t rows[7] = '{'{32'h1008, 8'h03, 0, 3}, '{32'h100A, 8'h03, 0, 3},
    '{32'h100C, 8'h03, 0, 6}, '{32'h1000, 8'h03, 0, 0}, '{32'h1018, 8'h03, 0, 0},
    '{32'h1018, 8'h03, 1, 3}, '{32'h1008, 8'h02, 0, 0}};
  logic [31:0] ic[3] = '{32'h0002_1048, 32'h0002_1008, 32'h0002_1049};
  logic [7:0] ie[3] = '{8'h01, 8'h00, 8'h00};
  always #50 clock_i = ~clock_i;
  gated_pulse_counter_with_diag gated_pulse_counter_with_diag_i(.clock_i, .reset_i, .address_i,
    .read_i, .write_i, .byteenable_i, .writedata_i, .readdata_o, .waitrequest_o,
    .io_in_i, .sense_gnd_i, .sense_sup_i, .sense_open_i, .io_out_o, .io_oe_o, .hw_irq_o,
    .irq_chan_o, .irq_event_o);
  field_model field_i(.clock_i, .io_out_i(io_out_o), .io_oe_i(io_oe_o), .io_in_o(io_in_i),
    .sense_gnd_o(sense_gnd_i), .sense_sup_o(sense_sup_i), .sense_open_o(sense_open_i));
  // interrupt pulses last one cycle, so they are counted where they occur
  always @(posedge clock_i) begin
    cyc++;
    if (hw_irq_o === 1'b1) irqs++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // avalon master: hold the request until waitrequest is sampled low
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clock_i);
    read_i <= ~wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    @(posedge clock_i);
    while (waitrequest_o !== 1'b0 && t < 40) begin
      t++;
      @(posedge clock_i);
    end
    if (t == 40) begin
      errors++;
      $display("unexpected at %0t: bus access never answered", $time);
    end
    rd = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus
  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task chk_reg(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    n_checks++;
    if (rd !== e) begin
      errors++;
      $display("unexpected at %0t: reg %h got %h want %h", $time, a, rd, e);
    end
  endtask : chk_reg
  task chk_pin(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: pins got %h want %h", $time, g, e);
    end
  endtask : chk_pin
  task rst;
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    irqs = 0;
  endtask : rst
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    foreach (rows[i]) begin
      rst();
      wr(OFS_CHEN, {24'h0, rows[i].chen});
      wr(OFS_CTRL, rows[i].ctrl);
      field_i.set_pin(1, rows[i].gate);
      field_i.pulses(3);
      chk_reg(OFS_COUNT, rows[i].cnt);
    end
    rst();
    chk_pin({7'h0, waitrequest_o}, 8'h01);
    chk_reg(OFS_CTRL, RST_CTRL);
    chk_reg(OFS_LIMIT, RST_LIMIT);
    chk_reg(OFS_CMP, RST_CMP);
    chk_reg(OFS_WIN, RST_WIN);
    chk_reg(OFS_DGST, 32'h0);
    wr(OFS_COUNT, 32'h0000_0055);
    chk_reg(OFS_COUNT, 32'h0);
    // a single lane write must leave the other three lanes of the limit alone
    byteenable_i <= 4'h1;
    wr(OFS_LIMIT, 32'h1234_5678);
    byteenable_i <= 4'hF;
    chk_reg(OFS_LIMIT, 32'hFFFF_FF78);
    chk_reg(6'h3C, 32'h0);
    // compare interrupt: enabled, locked, frequency mode
    for (int i = 0; i < 3; i++) begin
      rst();
      wr(OFS_CHEN, 32'h07);
      wr(OFS_DQ, 32'h0400);
      wr(OFS_CMP, 32'h2);
      wr(OFS_CTRL, ic[i]);
      field_i.pulses(2);
      chk_pin(irqs[7:0], ie[i]);
    end
    field_i.set_pin(1, 1'b0);
    rst();
    // count on channel 3 so a wrong channel field in the record shows up
    wr(OFS_CHEN, 32'h0F);
    wr(OFS_DQ, 32'h0400);
    wr(OFS_CMP, 32'h2);
    wr(OFS_CTRL, 32'h0002_1348);
    repeat (2) begin
      field_i.set_pin(3, 1'b1);
      field_i.set_pin(3, 1'b0);
    end
    chk_pin(io_out_o & 8'h04, 8'h04);
    chk_pin(irq_chan_o, 8'h03);
    chk_pin(irq_event_o, EV_CMP);
    chk_reg(OFS_IREC, 32'h0000_0503);
    // high limit: stop mode halts at zero until the gate reopens, continue runs on
    for (int s = 0; s < 2; s++) begin
      rst();
      wr(OFS_CHEN, 32'h03);
      wr(OFS_LIMIT, 32'h2);
      wr(OFS_CTRL, s ? 32'h1028 : 32'h1008);
      field_i.pulses(4);
      chk_reg(OFS_COUNT, s ? 32'h0 : 32'h1);
    end
    wr(OFS_CTRL, 32'h1020);
    wr(OFS_CTRL, 32'h1028);
    field_i.pulses(1);
    chk_reg(OFS_COUNT, 32'h1);
    // frequency: both-edge setting still counts rising edges per window
    rst();
    wr(OFS_CHEN, 32'h03);
    wr(OFS_WIN, 32'd100);
    wr(OFS_CTRL, 32'h100D);
    field_i.run(1'b1);
    repeat (350) @(posedge clock_i);
    chk_reg(OFS_FREQ, 32'd10);
    field_i.run(1'b0);
    // diagnostics on output channel 2, supply enable also on input channel 3
    rst();
    wr(OFS_CHEN, 32'h0F);
    wr(OFS_DQ, 32'h0404);
    wr(OFS_DGEN, 32'h0004_0C04);
    chk_pin(io_oe_o, 8'h04);
    field_i.set_sense(8'h04, 8'h08, 8'h04);
    chk_reg(OFS_DGST, 32'h0004_0004);
    field_i.set_sense(8'h00, 8'h0C, 8'h04);
    chk_reg(OFS_DGST, 32'h0004_0404);
    wr(OFS_DQ, 32'h0400);
    field_i.set_sense(8'h04, 8'h0C, 8'h04);
    chk_reg(OFS_DGST, 32'h0004_0400);
    wr(OFS_DGEN, 32'h0);
    chk_reg(OFS_DGST, 32'h0);
    complete_run();
  end
endmodule : tb_top
